// file: aofpc_pkg.sv
package aofpc_pkg;
    // ====================================================================
    // Register map
    localparam logic [7:0] AOFPC_PATTERN_TEST_CONTROL_ADDR = 8'h0D;
    localparam logic [7:0] AOFPC_FILTER_CUTOFF_SELECT_ADDR = 8'h0F;
    localparam logic [7:0] AOFPC_PREAMP_OFFSET_ADJUST_ADDR = 8'h10;
    localparam logic [7:0] AOFPC_PREAMP_GAIN_SELECT_ADDR   = 8'h11;
    localparam logic [7:0] AOFPC_SAMPLE_CODING_CONFIG_ADDR = 8'h14;
    localparam logic [7:0] AOFPC_LANE_DRIVER_CONFIG_ADDR   = 8'h15;
    localparam logic [7:0] AOFPC_OUT_CLOCK_PHASE_SEL_ADDR  = 8'h16;

    localparam logic [7:0] AOFPC_PATTERN_TEST_CONTROL_RST  = 8'h00;
    localparam logic [7:0] AOFPC_FILTER_CUTOFF_SELECT_RST  = 8'h30;
    localparam logic [7:0] AOFPC_PREAMP_OFFSET_ADJUST_RST  = 8'h20;
    localparam logic [7:0] AOFPC_PREAMP_GAIN_SELECT_RST    = 8'h01;
    localparam logic [7:0] AOFPC_SAMPLE_CODING_CONFIG_RST  = 8'h00;
    localparam logic [7:0] AOFPC_LANE_DRIVER_CONFIG_RST    = 8'h00;
    localparam logic [7:0] AOFPC_OUT_CLOCK_PHASE_SEL_RST   = 8'h03;

    // ====================================================================
    // Field positions
    localparam int AOFPC_TEST_MODE_LSB = 0;
    localparam int AOFPC_FMT_LSB       = 0;
    localparam int AOFPC_INVERT_BIT    = 2;
    localparam int AOFPC_PHASE_LSB     = 0;

    localparam logic [1:0] AOFPC_FMT_OFFSET = 2'h0;
    localparam logic [1:0] AOFPC_FMT_TWOS   = 2'h1;

    // ====================================================================
    // Serial port framing and clock divider
    localparam int AOFPC_SPI_INSTR_BITS = 16;
    localparam int AOFPC_SPI_FRAME_BITS = 24;
    localparam int AOFPC_DIV_STEPS      = 6;
    localparam int AOFPC_PHASE_MAX      = 10;

    typedef enum logic [3:0] {
        AOFPC_TP_OFF     = 4'h0,
        AOFPC_TP_MID     = 4'h1,
        AOFPC_TP_POS_FS  = 4'h2,
        AOFPC_TP_NEG_FS  = 4'h3,
        AOFPC_TP_CHECKER = 4'h4,
        AOFPC_TP_TOGGLE  = 4'h9
    } aofpc_tp_t;

    typedef struct packed {
        logic [3:0] test_mode;
        logic       invert;
        logic [1:0] fmt;
        logic [3:0] phase;
    } aofpc_cfg_t;
endpackage

// file: aofpc_top.sv
// Functional notes
// - Two-bit format code: 00 offset binary (reset), 01 twos complement.
// - Invert bit set complements every output data bit; reset is off.
// - Four-bit phase picks divider phase, 60 degree steps, codes above 10 held at 10, reset 0x03.
// - Phase selection moves only output clock; internal latching unchanged.
`timescale 1ns/1ps
`default_nettype none

// ========================================================================
// Sample FIFO
module aofpc_fifo #(
    parameter int W = 12,
    parameter int D = 8
) (
    input  wire logic         clk_sys_i,
    input  wire logic         rst_n_i,
    input  wire logic [W-1:0] in_data_i,
    input  wire logic         in_valid_i,
    output logic              in_ready_o,
    output logic [W-1:0]      out_data_o,
    output logic              out_valid_o,
    input  wire logic         out_ready_i
);
    localparam int AW = $clog2(D);
    if (D < 2 || (1 << AW) != D)
    begin : g_bad_depth
        $error("FIFO depth must be 2^n");
    end

    logic [W-1:0] mem [D];
    logic [AW:0]  wp_r;
    logic [AW:0]  rp_r;
    wire          push = in_valid_i && in_ready_o;
    wire          pop  = out_valid_o && out_ready_i;

    assign in_ready_o  = (wp_r - rp_r) != (AW+1)'(D);
    assign out_valid_o = wp_r != rp_r;
    assign out_data_o  = mem[rp_r[AW-1:0]];

    always_ff @(posedge clk_sys_i)
    begin
        if (push)
        begin
            mem[wp_r[AW-1:0]] <= in_data_i;
        end
        if (!rst_n_i)
        begin
            wp_r <= '0;
            rp_r <= '0;
        end
        else
        begin
            wp_r <= wp_r + (AW+1)'(push);
            rp_r <= rp_r + (AW+1)'(pop);
        end
    end
endmodule // aofpc_fifo

// ========================================================================
// Output format and phase control
module aofpc_top
    import aofpc_pkg::*;
#(
    parameter int W = 12,
    parameter int FIFO_DEPTH = 8
) (
    input  wire logic         clk_sys_i,
    input  wire logic         rst_n_i,
    input  wire logic         spi_sclk_i,
    input  wire logic         spi_cs_n_i,
    input  wire logic         spi_sdio_i,
    output logic              spi_sdio_o,
    output logic              spi_sdio_oe_n_o,
    input  wire logic [W-1:0] sample_i,
    input  wire logic         sample_valid_i,
    output logic              sample_ready_o,
    output logic              lane_o,
    output logic              frame_clk_o,
    output logic              out_clk_o,
    output logic [7:0]        filter_cutoff_o,
    output logic [7:0]        preamp_offset_o,
    output logic [7:0]        preamp_gain_o,
    output logic [7:0]        lane_driver_o
);
    if (W < 2 || W > 16)
    begin : g_bad_width
        $error("Sample width out of range");
    end

    // ====================================================================
    // Register bank and serial configuration port
    logic [7:0] test_r, coding_r, phase_r;
    logic [7:0] cutoff_r, offs_r, gain_r, drv_r;
    logic       sclk_q_r;
    logic [4:0] spi_cnt_r;
    logic [15:0] spi_sh_r;
    logic       spi_rd_r;
    logic [7:0] rd_sh_r;

    wire sclk_rise = spi_sclk_i && !sclk_q_r;
    wire sclk_fall = !spi_sclk_i && sclk_q_r;
    wire spi_last  = sclk_rise && spi_cnt_r == 5'(AOFPC_SPI_FRAME_BITS - 1);
    wire spi_instr = sclk_rise && spi_cnt_r == 5'(AOFPC_SPI_INSTR_BITS - 1);
    wire [15:0] instr_word = {spi_sh_r[14:0], spi_sdio_i};
    wire [7:0]  wr_addr    = spi_sh_r[14:7];
    wire [7:0]  wr_data    = {spi_sh_r[6:0], spi_sdio_i};
    wire        do_write   = spi_last && !spi_cs_n_i && !spi_rd_r;

    function automatic logic [7:0] rd_mux(input logic [7:0] a);
        unique case (a)
            AOFPC_PATTERN_TEST_CONTROL_ADDR: rd_mux = test_r;
            AOFPC_FILTER_CUTOFF_SELECT_ADDR: rd_mux = cutoff_r;
            AOFPC_PREAMP_OFFSET_ADJUST_ADDR: rd_mux = offs_r;
            AOFPC_PREAMP_GAIN_SELECT_ADDR:   rd_mux = gain_r;
            AOFPC_SAMPLE_CODING_CONFIG_ADDR: rd_mux = coding_r;
            AOFPC_LANE_DRIVER_CONFIG_ADDR:   rd_mux = drv_r;
            AOFPC_OUT_CLOCK_PHASE_SEL_ADDR:  rd_mux = phase_r;
            default:                         rd_mux = 8'h00;
        endcase
    endfunction

    always_ff @(posedge clk_sys_i)
    begin
        if (!rst_n_i || spi_cs_n_i)
        begin
            sclk_q_r        <= 1'b0;
            spi_cnt_r       <= 5'h00;
            spi_sh_r        <= 16'h0000;
            spi_rd_r        <= 1'b0;
            rd_sh_r         <= 8'h00;
            spi_sdio_oe_n_o <= 1'b1;
            spi_sdio_o      <= 1'b0;
        end
        else
        begin
            sclk_q_r <= spi_sclk_i;
            if (sclk_rise)
            begin
                spi_sh_r  <= instr_word;
                spi_cnt_r <= spi_last ? 5'h00 : spi_cnt_r + 5'h01;
            end
            if (spi_instr)
            begin
                // Read flag is the first bit of the frame
                spi_rd_r <= spi_sh_r[14];
                rd_sh_r  <= rd_mux(instr_word[7:0]);
            end
            if (spi_last)
            begin
                spi_rd_r        <= 1'b0;
                spi_sdio_oe_n_o <= 1'b1;
            end
            else if (sclk_fall && spi_rd_r)
            begin
                spi_sdio_oe_n_o <= 1'b0;
                spi_sdio_o      <= rd_sh_r[7];
                rd_sh_r         <= {rd_sh_r[6:0], 1'b0};
            end
        end
    end

    always_ff @(posedge clk_sys_i)
    begin
        if (!rst_n_i)
        begin
            test_r   <= AOFPC_PATTERN_TEST_CONTROL_RST;
            cutoff_r <= AOFPC_FILTER_CUTOFF_SELECT_RST;
            offs_r   <= AOFPC_PREAMP_OFFSET_ADJUST_RST;
            gain_r   <= AOFPC_PREAMP_GAIN_SELECT_RST;
            coding_r <= AOFPC_SAMPLE_CODING_CONFIG_RST;
            drv_r    <= AOFPC_LANE_DRIVER_CONFIG_RST;
            phase_r  <= AOFPC_OUT_CLOCK_PHASE_SEL_RST;
        end
        else if (do_write)
        begin
            if (wr_addr == AOFPC_PATTERN_TEST_CONTROL_ADDR) test_r <= wr_data;
            if (wr_addr == AOFPC_FILTER_CUTOFF_SELECT_ADDR) cutoff_r <= wr_data;
            if (wr_addr == AOFPC_PREAMP_OFFSET_ADJUST_ADDR) offs_r <= wr_data;
            if (wr_addr == AOFPC_PREAMP_GAIN_SELECT_ADDR)   gain_r <= wr_data;
            if (wr_addr == AOFPC_SAMPLE_CODING_CONFIG_ADDR) coding_r <= wr_data;
            if (wr_addr == AOFPC_LANE_DRIVER_CONFIG_ADDR)   drv_r <= wr_data;
            if (wr_addr == AOFPC_OUT_CLOCK_PHASE_SEL_ADDR)  phase_r <= wr_data;
        end
    end

    assign filter_cutoff_o = cutoff_r;
    assign preamp_offset_o = offs_r;
    assign preamp_gain_o   = gain_r;
    assign lane_driver_o   = drv_r;

    aofpc_cfg_t cfg;
    assign cfg.test_mode = test_r[AOFPC_TEST_MODE_LSB +: 4];
    assign cfg.invert    = coding_r[AOFPC_INVERT_BIT];
    assign cfg.fmt       = coding_r[AOFPC_FMT_LSB +: 2];
    assign cfg.phase     = phase_r[AOFPC_PHASE_LSB +: 4];

    // ====================================================================
    // Sample path: FIFO, pattern select, coding, serialiser
    logic [W-1:0] fifo_data;
    logic         fifo_valid;
    logic [3:0]   bit_cnt_r;
    logic [W-1:0] ser_r;
    logic         tgl_r;
    wire          load = bit_cnt_r == 4'h0;

    aofpc_fifo #(.W(W), .D(FIFO_DEPTH)) u_fifo (
        .clk_sys_i   (clk_sys_i),
        .rst_n_i     (rst_n_i),
        .in_data_i   (sample_i),
        .in_valid_i  (sample_valid_i),
        .in_ready_o  (sample_ready_o),
        .out_data_o  (fifo_data),
        .out_valid_o (fifo_valid),
        .out_ready_i (load)
    );

    // Missing sample on a word slot sends midscale rather than stalling
    wire [W-1:0] mid   = {1'b1, {(W-1){1'b0}}};
    wire [W-1:0] src   = fifo_valid ? fifo_data : mid;
    wire [W-1:0] tp    =
        cfg.test_mode == AOFPC_TP_MID     ? mid :
        cfg.test_mode == AOFPC_TP_POS_FS  ? {W{1'b1}} :
        cfg.test_mode == AOFPC_TP_NEG_FS  ? {W{1'b0}} :
        cfg.test_mode == AOFPC_TP_CHECKER ? {(W/2){tgl_r, !tgl_r}} :
        cfg.test_mode == AOFPC_TP_TOGGLE  ? {W{tgl_r}} : mid;
    wire [W-1:0] sel   = (cfg.test_mode == AOFPC_TP_OFF) ? src : tp;
    wire [W-1:0] coded = (cfg.fmt == AOFPC_FMT_TWOS) ?
                         {!sel[W-1], sel[W-2:0]} : sel;
    wire [W-1:0] word  = cfg.invert ? ~coded : coded;

    always_ff @(posedge clk_sys_i)
    begin
        if (!rst_n_i)
        begin
            bit_cnt_r   <= 4'h0;
            ser_r       <= '0;
            tgl_r       <= 1'b0;
            lane_o      <= 1'b0;
            frame_clk_o <= 1'b0;
        end
        else
        begin
            bit_cnt_r   <= (bit_cnt_r == 4'(W - 1)) ? 4'h0 : bit_cnt_r + 4'h1;
            ser_r       <= load ? word : {ser_r[W-2:0], 1'b0};
            tgl_r       <= load ? !tgl_r : tgl_r;
            lane_o      <= load ? word[W-1] : ser_r[W-2];
            frame_clk_o <= bit_cnt_r < 4'(W / 2);
        end
    end

    // ====================================================================
    // Output clock: divider phases, one sys cycle per 60 degree step.
    // Only the tap moves; divider and serialiser never see the phase.
    logic [2:0]              div_r;
    logic [AOFPC_PHASE_MAX:0] dly_r;
    wire                     base = div_r < 3'(AOFPC_DIV_STEPS / 2);
    wire [3:0]               tap  = (cfg.phase > 4'(AOFPC_PHASE_MAX)) ?
                                    4'(AOFPC_PHASE_MAX) : cfg.phase;

    always_ff @(posedge clk_sys_i)
    begin
        if (!rst_n_i)
        begin
            div_r     <= 3'h0;
            dly_r     <= '0;
            out_clk_o <= 1'b0;
        end
        else
        begin
            div_r     <= (div_r == 3'(AOFPC_DIV_STEPS - 1)) ? 3'h0 : div_r + 3'h1;
            dly_r     <= {dly_r[AOFPC_PHASE_MAX-1:0], base};
            out_clk_o <= dly_r[tap];
        end
    end

    // ====================================================================
    // Checks
    a_fmt_twos_msb: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        load && cfg.test_mode == 4'h0 && !cfg.invert && fifo_valid &&
        cfg.fmt == AOFPC_FMT_TWOS |=> lane_o == !$past(fifo_data[W-1]))
        else $error("twos complement msb wrong");
    a_fmt_offs_msb: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        load && cfg.test_mode == 4'h0 && !cfg.invert && fifo_valid &&
        cfg.fmt == AOFPC_FMT_OFFSET |=> lane_o == $past(fifo_data[W-1]))
        else $error("offset binary msb wrong");
    a_invert_data: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        load && cfg.invert |=> lane_o == !$past(coded[W-1]))
        else $error("inversion not applied");
    a_phase_tap: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        $stable(cfg.phase) && cfg.phase <= 4'h3 && $past(cfg.phase) == 4'h3
        |=> out_clk_o == $past(dly_r[3]))
        else $error("output clock phase tap wrong");
    a_latch_fixed: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        bit_cnt_r == 4'(W - 1) |=> bit_cnt_r == 4'h0 ##1 bit_cnt_r == 4'h1)
        else $error("word timing disturbed");
    a_test_fullscale: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        load && cfg.test_mode == AOFPC_TP_POS_FS && cfg.fmt == AOFPC_FMT_OFFSET
        && !cfg.invert |=> lane_o ##1 lane_o ##1 lane_o)
        else $error("test pattern not driven");
endmodule // aofpc_top
`default_nettype wire

// file: aofpc_rx_model.sv
`timescale 1ns/1ps
`default_nettype none
// ========
// Lane receiver, word framed by the frame clock rise
module aofpc_rx_model #(
    parameter int W = 12
) (
    input  wire logic         clk_sys_i,
    input  wire logic         lane_i,
    input  wire logic         frame_clk_i,
    output logic [W-1:0]      word_o,
    output logic              word_stb_o
);
    logic         fc_q = 1'b0;
    logic [W-1:0] sh   = '0;
    int           cnt  = W;
    always @(posedge clk_sys_i)
    begin
        sh = {sh[W-2:0], lane_i};
        if (frame_clk_i && !fc_q)
            cnt = 0;
        word_stb_o <= (cnt == W - 1);
        if (cnt == W - 1)
            word_o <= sh;
        if (cnt < W)
            cnt++;
        fc_q <= frame_clk_i;
    end
endmodule // aofpc_rx_model
`default_nettype wire

// file: aofpc_top_test.sv
`timescale 1ns/1ps
`default_nettype none
module aofpc_top_test;
    import aofpc_pkg::*;
    localparam int W = 12;
    localparam logic [W-1:0] MID = 12'h800;
    localparam logic [7:0] ADR [7] = '{8'h0D, 8'h0F, 8'h10, 8'h11, 8'h14,
                                       8'h15, 8'h16};
    localparam logic [7:0] RST [7] = '{8'h00, 8'h30, 8'h20, 8'h01, 8'h00,
                                       8'h00, 8'h03};
    localparam logic [3:0] MODES [6] = '{4'h1, 4'h2, 4'h3, 4'h4, 4'h9, 4'h7};
    logic         clk_sys_i = 1'b0;
    logic         rst_n_i   = 1'b0;
    logic         sclk      = 1'b0;
    logic         cs_n      = 1'b1;
    logic         sdio_drv  = 1'b0;
    logic [W-1:0] sample    = '0;
    logic         svalid    = 1'b0;
    wire          sdio_o, sdio_oe_n, sready, lane, fclk, oclk, stb;
    wire [7:0]    flt, pof, pgn, ldrv;
    wire [W-1:0]  rx_word;
    // Pin level: the device wins while its enable is low
    wire          sdio_w = sdio_oe_n ? sdio_drv : sdio_o;
    int           mismatches = 0;
    int           n_checks   = 0;
    int           cyc        = 0;
    integer       seed       = 32'hbc2b874e;
    logic [W-1:0] sq [$];
    logic [W-1:0] prev_w = '0;
    logic [1:0]   fmt    = 2'h0;
    logic [3:0]   tm     = 4'h0;
    logic         inv = 1'b0, chk_en = 1'b0, saw_full = 1'b0;
    logic         fc_q = 1'b0, oc_q = 1'b0;

    always #20 clk_sys_i = ~clk_sys_i;

    aofpc_top #(.W(W), .FIFO_DEPTH(8)) aofpc_top_i (
        .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .spi_sclk_i(sclk),
        .spi_cs_n_i(cs_n), .spi_sdio_i(sdio_w), .spi_sdio_o(sdio_o),
        .spi_sdio_oe_n_o(sdio_oe_n), .sample_i(sample),
        .sample_valid_i(svalid), .sample_ready_o(sready), .lane_o(lane),
        .frame_clk_o(fclk), .out_clk_o(oclk), .filter_cutoff_o(flt),
        .preamp_offset_o(pof), .preamp_gain_o(pgn), .lane_driver_o(ldrv));
    aofpc_rx_model #(.W(W)) aofpc_rx_model_i (.clk_sys_i(clk_sys_i),
        .lane_i(lane), .frame_clk_i(fclk), .word_o(rx_word),
        .word_stb_o(stb));

    // ========
    // Compare and close
    task automatic cmp_byte(input logic [7:0] got, input logic [7:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            mismatches++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic cmp_word(input logic [W-1:0] got, input logic [W-1:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            mismatches++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic conclude();
        if (mismatches == 0 && n_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys_i);
    endtask

    // ========
    // Serial configuration port, sclk half period of 4 clocks
    task automatic spi(input logic rd, input logic [7:0] a,
                       input logic [7:0] d, output logic [7:0] q);
        logic [23:0] f;
        f = {rd, 7'h00, a, d};
        cs_n <= 1'b0;
        for (int i = 0; i < 24; i++)
        begin
            sclk <= 1'b0;
            sdio_drv <= f[23-i];
            tick(4);
            if (i > 15)
                q = {q[6:0], sdio_w};
            sclk <= 1'b1;
            tick(4);
        end
        sclk <= 1'b0;
        tick(2);
        cs_n <= 1'b1;
        tick(4);
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [7:0] q;
        spi(1'b0, a, d, q);
    endtask
    task automatic rdc(input logic [7:0] a, input logic [7:0] e);
        logic [7:0] q;
        spi(1'b1, a, 8'h00, q);
        cmp_byte(q, e);
    endtask

    // ========
    // Stream model
    function automatic logic [W-1:0] code(input logic [W-1:0] v);
        v[W-1] = v[W-1] ^ (fmt == 2'h1);
        return inv ? ~v : v;
    endfunction
    function automatic logic [W-1:0] rnd();
        logic [W-1:0] v;
        v = $random(seed);
        // Midscale is reserved to tell filler words apart
        return (v == MID) ? v ^ 1 : v;
    endfunction
    task automatic chk_word(input logic [W-1:0] w);
        logic [W-1:0] e;
        case (tm)
            4'h0: e = sq.size() ? sq[0] : MID;
            4'h2: e = 12'hFFF;
            4'h3: e = 12'h000;
            4'h4: e = (prev_w === code(12'hAAA)) ? 12'h555 : 12'hAAA;
            4'h9: e = (prev_w === code(12'hFFF)) ? 12'h000 : 12'hFFF;
            default: e = MID;
        endcase
        if (tm == 0 && sq.size() && w === code(MID))
            return;
        if (tm == 0 && sq.size())
            void'(sq.pop_front());
        cmp_word(w, code(e));
    endtask
    task automatic stream(input int n, input logic dense);
        int k = 0;
        while (k < n || (svalid && !sready))
        begin
            @(posedge clk_sys_i);
            if (!svalid || sready)
            begin
                k++;
                svalid <= (k < n) && (dense || ($random(seed) & 1));
                sample <= rnd();
            end
        end
    endtask
    task automatic drain();
        for (int t = 0; t < 600 && sq.size() > 0; t++)
            tick(1);
        cmp_word(W'(sq.size()), '0);
    endtask
    task automatic phase_off(output int off);
        off = 0;
        while (!(fclk && !fc_q))
            tick(1);
        while (!(oclk && !oc_q))
        begin
            tick(1);
            off++;
        end
    endtask

    always @(posedge clk_sys_i)
    begin
        cyc++;
        fc_q <= fclk;
        oc_q <= oclk;
        if (svalid && sready)
            sq.push_back(sample);
        if (svalid && !sready)
            saw_full <= 1'b1;
        if (stb === 1'b1)
        begin
            if (chk_en)
                chk_word(rx_word);
            prev_w <= rx_word;
        end
        if (cyc == 40000)
        begin
            mismatches++;
            conclude();
        end
    end

    // ========
    // Main sequence
    initial
    begin
        logic [7:0] v [4];
        int off, base;
        tick(4);
        rst_n_i <= 1'b1;
        tick(2);
        for (int i = 0; i < 7; i++)
            rdc(ADR[i], RST[i]);
        wr(8'h0E, 8'h5A);
        rdc(8'h0E, 8'h00);
        for (int i = 0; i < 4; i++)
        begin
            v[i] = $random(seed);
            wr(ADR[i < 3 ? i + 1 : 5], v[i]);
            rdc(ADR[i < 3 ? i + 1 : 5], v[i]);
        end
        cmp_byte(flt, v[0]);
        cmp_byte(pof, v[1]);
        cmp_byte(pgn, v[2]);
        cmp_byte(ldrv, v[3]);
        for (int f = 0; f < 4; f++)
        begin
            wr(8'h14, {5'h00, f[1], 1'b0, f[0]});
            rdc(8'h14, {5'h00, f[1], 1'b0, f[0]});
            fmt <= {1'b0, f[0]};
            inv <= f[1];
            // Words already loaded still carry the old coding
            tick(3 * W);
            chk_en <= 1'b1;
            stream(20, f[0]);
            drain();
            chk_en <= 1'b0;
        end
        cmp_byte({7'h00, saw_full}, 8'h01);
        foreach (MODES[i])
        begin
            wr(8'h0D, {4'h0, MODES[i]});
            tm <= MODES[i];
            tick(3 * W);
            chk_en <= 1'b1;
            tick(8 * W);
            chk_en <= 1'b0;
        end
        wr(8'h0D, 8'h00);
        tm <= 4'h0;
        tick(3 * W);
        chk_en <= 1'b1;
        fork
            stream(150, 1'b0);
            for (int p = 0; p < 13; p++)
            begin
                wr(8'h16, p[7:0]);
                rdc(8'h16, p[7:0]);
                phase_off(off);
                if (p == 0)
                    base = off;
                cmp_byte(off[7:0], 8'((base + (p > 10 ? 10 : p)) % 6));
            end
        join
        drain();
        conclude();
    end
endmodule // aofpc_top_test
`default_nettype wire
